// ==== design/change_notify_pkg.sv ====
// package: register map, field layout and types of the input change notifier
package change_notify_pkg;

   // register offsets (byte addresses of 16-bit registers)
   localparam logic [15:0] ADDR_IRQ_EN_LOW   = 16'h00c0;
   localparam logic [15:0] ADDR_IRQ_EN_HIGH  = 16'h00c2;
   localparam logic [15:0] ADDR_PULLUP_LOW   = 16'h00c4;
   localparam logic [15:0] ADDR_PULLUP_HIGH  = 16'h00c6;
   localparam logic [15:0] ADDR_STATUS       = 16'h00c8;

   localparam int          REG_W             = 16;
   localparam int          MAX_LINES         = 24;
   localparam logic [15:0] REG_RESET         = 16'h0000;
   localparam logic [15:0] RD_UNMAPPED       = 16'h0000;

   // status register fields
   localparam int          STAT_PEND_BIT     = 0;
   localparam logic [15:0] STAT_CLR_MASK     = 16'h0001;

   typedef struct packed
   {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

endpackage

// ==== design/input_change_notifier.sv ====
// input change notifier: per-line change detect, irq/pull-up enables, register port
//
// Function
// R1 - an enabled watched line changing level raises the interrupt request
// R2 - detection works with the core clocks stopped, via the sleep path; here sleep_wake_o is registered on clk_sys_i and needs that clock
// R3 - up to 24 watched lines, numbered 0 to 23, each watched independently
// R4 - one irq enable bit per line; a disabled line never raises a request
// R5 - one pull-up enable bit per line, independent of the irq enable
// R6 - compare present level to sampled level; mismatch sets pending, sample updates
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps

module input_change_notifier
   import change_notify_pkg::*;
#(
   parameter int NUM_LINES = MAX_LINES
)
(
   // clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 rstn_i,
   // register port
   input  wire reg_req_t             req_i,
   output logic [REG_W-1:0]          rdata_o,
   // watched pins and pull-up controls
   input  wire logic [NUM_LINES-1:0] watched_input_lines_i,
   output logic [NUM_LINES-1:0]      pullup_en_o,
   // sleep-mode wake path and interrupt request
   output logic                      sleep_wake_o,
   output logic                      irq_o
);

   // refuse widths outside 1 to MAX_LINES (24), at elaboration
   if (NUM_LINES < 1 || NUM_LINES > MAX_LINES)
   begin : g_bad_width
      $error("NUM_LINES must lie in 1..24");
   end

   logic [2*REG_W-1:0]     irq_en_q;
   logic [2*REG_W-1:0]     pullup_q;
   logic [NUM_LINES-1:0]   sample_q;
   logic [NUM_LINES-1:0]   per_input_irq_enable;
   logic [NUM_LINES-1:0]   per_input_pullup_enable;
   logic [NUM_LINES-1:0]   change_d;
   logic                   pending_q;
   logic                   clr_pend;
   logic [REG_W-1:0]       rdata_d;
   logic [2*REG_W-1:0]     impl_mask;

   // only implemented lines hold storage; the rest read as zero
   always_comb
   begin
      impl_mask = '0;
      impl_mask[NUM_LINES-1:0] = '1;
   end

   assign per_input_irq_enable    = irq_en_q[NUM_LINES-1:0];     // R4
   assign per_input_pullup_enable = pullup_q[NUM_LINES-1:0];     // R5

   // irq enable registers
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         irq_en_q <= {REG_RESET, REG_RESET};
      else if (req_i.wr && req_i.addr == ADDR_IRQ_EN_LOW)
         irq_en_q[REG_W-1:0] <= req_i.wdata & impl_mask[REG_W-1:0];
      else if (req_i.wr && req_i.addr == ADDR_IRQ_EN_HIGH)
         irq_en_q[2*REG_W-1:REG_W] <= req_i.wdata & impl_mask[2*REG_W-1:REG_W];
   end

   // pull-up enable registers
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pullup_q <= {REG_RESET, REG_RESET};
      else if (req_i.wr && req_i.addr == ADDR_PULLUP_LOW)
         pullup_q[REG_W-1:0] <= req_i.wdata & impl_mask[REG_W-1:0];
      else if (req_i.wr && req_i.addr == ADDR_PULLUP_HIGH)
         pullup_q[2*REG_W-1:REG_W] <= req_i.wdata & impl_mask[2*REG_W-1:REG_W];
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pullup_en_o <= '0;
      else
         pullup_en_o <= per_input_pullup_enable;                 // R5
   end

   // one independent comparator per line
   genvar g;
   generate
      for (g = 0; g < NUM_LINES; g++)
      begin : g_line
         assign change_d[g] = per_input_irq_enable[g]
                              && (watched_input_lines_i[g] != sample_q[g]); // R3 R6
      end
   endgenerate

   // sampled level follows the pin every cycle; a reset value of zero means a line
   // already high at release reports no change, as the first edge loads the pin before any enable is set
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         sample_q <= '0;
      else
         sample_q <= watched_input_lines_i;                      // R6
   end

   assign clr_pend = req_i.wr && req_i.addr == ADDR_STATUS
                     && (req_i.wdata & STAT_CLR_MASK) != '0;

   // pending request: a new change wins over a clear in the same cycle
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         pending_q <= 1'b0;
      else if (|change_d)
         pending_q <= 1'b1;                                      // R1 R4 R6
      else if (clr_pend)
         pending_q <= 1'b0;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         irq_o <= 1'b0;
      else
         irq_o <= pending_q || (|change_d);                      // R1
   end

   // with clocks stopped the sampled levels freeze, so any enabled line differing
   // from them is a change; this flop is clocked by clk_sys_i, so sleep_wake_o only rises once that clock runs
   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         sleep_wake_o <= 1'b0;
      else
         sleep_wake_o <= |change_d;                              // R2
   end

   // read mux
   always_comb
   begin
      unique case (req_i.addr)
         ADDR_IRQ_EN_LOW:  rdata_d = irq_en_q[REG_W-1:0];
         ADDR_IRQ_EN_HIGH: rdata_d = irq_en_q[2*REG_W-1:REG_W];
         ADDR_PULLUP_LOW:  rdata_d = pullup_q[REG_W-1:0];
         ADDR_PULLUP_HIGH: rdata_d = pullup_q[2*REG_W-1:REG_W];
         ADDR_STATUS:
         begin
            rdata_d = '0;
            rdata_d[STAT_PEND_BIT] = pending_q;
         end
         default:          rdata_d = RD_UNMAPPED;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rdata_o <= '0;
      else if (req_i.rd)
         rdata_o <= rdata_d;
      else
         rdata_o <= '0;
   end

endmodule

// ==== verif/pin_model.sv ====
// partner: driven, pulled-up and floating pins
`timescale 1ns/10ps
module pin_model (
   // pin controls and levels
   input  wire logic [23:0] pu_i,
   input  wire logic [23:0] oe_i,
   input  wire logic [23:0] drv_i,
   output logic [23:0]      pin_o
);
   logic flip = 1'b0;
   always #40 flip = ~flip; // floats hold no level; moves on the falling clock edge, off the rising one
   assign pin_o = oe_i & drv_i | ~oe_i & (pu_i | {24{flip}});
endmodule

// ==== verif/icn_asserts.sv ====
// checker: notifier port assertions
`timescale 1ns/10ps
module icn_asserts import change_notify_pkg::*; #(parameter int NUM_LINES = MAX_LINES) (
   // notifier ports
   input wire logic                 clk_sys_i,
   input wire logic                 rstn_i,
   input wire reg_req_t             req_i,
   input wire logic [REG_W-1:0]     rdata_o,
   input wire logic [NUM_LINES-1:0] watched_input_lines_i,
   input wire logic [NUM_LINES-1:0] pullup_en_o,
   input wire logic                 sleep_wake_o,
   input wire logic                 irq_o
);
   wire [15:0] a = req_i.addr;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   sequence en_wr; req_i.wr && a == ADDR_IRQ_EN_LOW; endsequence
   sequence en_rd; req_i.rd && a == ADDR_IRQ_EN_LOW; endsequence
   irq_hold_a: assert property (irq_o && !req_i.wr && !$past(req_i.wr) |=> irq_o)
      else $error("irq drop");
   wake_irq_a: assert property (sleep_wake_o |-> irq_o) else $error("wake alone");
   wake_why_a: assert property (sleep_wake_o |->
      $past(watched_input_lines_i) != $past(watched_input_lines_i, 2)) else $error("wake");
   high_bits_a: assert property (req_i.rd && a == ADDR_IRQ_EN_HIGH |=>
      rdata_o >> (NUM_LINES - 16) == 16'h0000) else $error("high bits");
   en_back_a: assert property (en_wr ##2 en_rd |=> rdata_o == $past(req_i.wdata, 3))
      else $error("readback");
   pu_copy_a: assert property (req_i.wr && a == ADDR_PULLUP_LOW |=> ##1
      pullup_en_o[15:0] == $past(req_i.wdata, 2)) else $error("pullup");
endmodule
bind input_change_notifier icn_asserts #(.NUM_LINES(NUM_LINES)) icn_asserts_inst (.*);

// ==== verif/input_change_notifier_tb.sv ====
// bench: notifier registers and change detection
`timescale 1ns/10ps
module input_change_notifier_tb import change_notify_pkg::*; ;
   logic        clk_sys_i = 1'b0, rstn_i = 1'b0, sleep_wake_o, irq_o;
   reg_req_t    req_i = '0;
   logic [15:0] rdata_o;
   logic [23:0] watched_input_lines_i, pullup_en_o, drv = '0;
   int          num_errors = 0, n_tests = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   input_change_notifier input_change_notifier_inst (.*);
   // lines 4..15 float; all but pulled-up line 5 toggle, so disabled lines see traffic all run
   pin_model pin_model_inst (.pu_i(pullup_en_o), .oe_i(24'hff000f), .drv_i(drv),
      .pin_o(watched_input_lines_i));
   task automatic chk(string s, logic [23:0] v, e);
      n_tests++;
      num_errors += int'(v !== e);
      if (v !== e)
         $display("wrong value %s exp %h seen %h", s, e, v);
   endtask
   task automatic acc(logic w, logic [15:0] a, d);
      @(posedge clk_sys_i) req_i <= '{a, d, w, !w};
      @(posedge clk_sys_i) req_i <= '0;
      #1 if (!w) chk("rdata", 24'(rdata_o), 24'(d));
   endtask
   task automatic results(int late);
      $display("errors %0d tests %0d", num_errors + late, n_tests);
      if (num_errors + late == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #100us;
      results(1);
   end
   initial
   begin
      repeat (2) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      for (int a = 'hc0; a <= 'hca; a += 2)
         acc(0, 16'(a), 16'h0000);
      acc(1, ADDR_PULLUP_LOW, 16'h0020);
      acc(1, ADDR_IRQ_EN_LOW, 16'h0021);
      acc(0, ADDR_IRQ_EN_LOW, 16'h0021);
      @(posedge clk_sys_i) drv <= 24'h000001;
      repeat (2) @(negedge clk_sys_i);
      chk("wake irq", {22'h0, sleep_wake_o, irq_o}, 24'h3);
      acc(0, ADDR_STATUS, 16'h0001);
      acc(1, ADDR_STATUS, STAT_CLR_MASK);
      repeat (2) @(negedge clk_sys_i);
      chk("irq", 24'(irq_o), 24'h0);
      acc(1, ADDR_IRQ_EN_HIGH, 16'hffff);
      acc(0, ADDR_IRQ_EN_HIGH, 16'h00ff);
      @(posedge clk_sys_i) drv <= 24'h800001;
      repeat (2) @(negedge clk_sys_i);
      chk("irq", 24'(irq_o), 24'h1);
      results(0);
   end
endmodule
